// ### include/sgcf_defs.vh
// Constants for the serial gated clock fanout block
`ifndef SGCF_DEFS_VH
`define SGCF_DEFS_VH

`define SGCF_NUM_COPIES 10
`define SGCF_SLAVE_ADDR 7'h69
`define SGCF_NUM_CFG_BYTES 3
`define SGCF_MAX_BYTE_COUNT 8'h20
`define SGCF_BYTE_IDX_ADDR 6'h00
`define SGCF_BYTE_IDX_CMD 6'h01
`define SGCF_BYTE_IDX_COUNT 6'h02
`define SGCF_BYTE_IDX_DATA0 6'h03

`define SGCF_CFG0_RST 8'h0F
`define SGCF_CFG1_RST 8'hF0
`define SGCF_CFG2_RST 8'hC0

`define SGCF_REG_CTRL 4'h0
`define SGCF_REG_GATE 4'h4
`define SGCF_REG_STATUS 4'h8
`define SGCF_REG_APPLIED 4'hC

`define SGCF_CTRL_EN_BIT 0
`define SGCF_CTRL_RST 32'h0000_0001
`define SGCF_STAT_BUSY_BIT 16

`define SGCF_RESP_OKAY 2'h0
`define SGCF_RESP_SLVERR 2'h2

`endif

// ### rtl/sgcf_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sgcf_sync #(
  parameter W = 4
) (
  input wire i_clk,
  input wire i_rst,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_level
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  integer k;

  // First stage feeds only the second; a change counts once stages two and three agree
  always @(posedge i_clk) begin
    if (i_rst) begin
      s1_ff <= {W{1'b1}};
      s2_ff <= {W{1'b1}};
      s3_ff <= {W{1'b1}};
      o_level <= {W{1'b1}};
    end else begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (k = 0; k < W; k = k + 1) begin
        if (s2_ff[k] == s3_ff[k]) begin
          o_level[k] <= s2_ff[k];
        end
      end
    end
  end
endmodule

// ### rtl/sgcf_fanout.v
// Gated clock fanout stage with registered copies
`timescale 1ns/1ps
module sgcf_fanout #(
  parameter N = 10
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_src_clk,
  input wire i_oe,
  input wire [N-1:0] i_gate_cfg,
  output reg [N-1:0] o_copy,
  output reg [N-1:0] o_copy_oe_n,
  output reg [N-1:0] o_gate_applied
);
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_copy <= {N{1'b0}};
      o_copy_oe_n <= {N{1'b1}};
      o_gate_applied <= {N{1'b0}};
    end else begin
      // Gates change only while the source is low, so no pulse is cut short
      if (!i_src_clk) begin
        o_gate_applied <= i_gate_cfg;
      end
      o_copy <= {N{i_oe & i_src_clk}} & o_gate_applied;
      o_copy_oe_n <= {N{~i_oe}};
    end
  end
endmodule

// ### rtl/sgcf_top.v
// Serial gated clock fanout: two-wire write-only slave, fanout and register port
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sgcf_defs.vh"
module sgcf_top #(
  parameter N = `SGCF_NUM_COPIES
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_src_clk,
  input wire i_oe,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda,
  output reg o_sda_oe_n,
  output wire [N-1:0] o_fanout_copy_n,
  output wire [N-1:0] o_fanout_copy_n_oe_n,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RECV = 4'b0010;
  localparam [3:0] ST_ACK = 4'b0100;
  localparam [3:0] ST_DROP = 4'b1000;

  wire [3:0] lvl;
  wire scl_s = lvl[0];
  wire sda_s = lvl[1];
  // Source and enable pass inverted, so the idle-high sync reset reads as off, not on
  wire src_s = ~lvl[2];
  wire oe_s = ~lvl[3];
  wire [N-1:0] gate_applied;

  reg scl_d_ff;
  reg sda_d_ff;
  reg [3:0] state_ff;
  reg [3:0] bit_cnt_ff;
  reg [7:0] shift_ff;
  reg [5:0] byte_idx_ff;
  reg [7:0] cmd_ff;
  reg [7:0] bcount_ff;
  reg [7:0] data_cnt_ff;
  reg [7:0] cfg0_ff;
  reg [7:0] cfg1_ff;
  reg [7:0] cfg2_ff;
  reg [31:0] ctrl_ff;
  reg aw_have_ff;
  reg w_have_ff;
  reg [3:0] awaddr_ff;
  reg aw_err_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  sgcf_sync #(
    .W(4)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({~i_oe, ~i_src_clk, i_sda, i_scl}),
    .o_level(lvl)
  );

  // Ten copies drawn from bits 3:0 of byte 0, 7:4 of byte 1 and 7:6 of byte 2
  wire [N-1:0] gate_cfg = {cfg2_ff[7:6], cfg1_ff[7:4], cfg0_ff[3:0]};

  sgcf_fanout #(
    .N(N)
  ) u_fanout (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_src_clk(src_s),
    .i_oe(oe_s),
    .i_gate_cfg(gate_cfg),
    .o_copy(o_fanout_copy_n),
    .o_copy_oe_n(o_fanout_copy_n_oe_n),
    .o_gate_applied(gate_applied)
  );

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire stop_ev = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire slave_en = ctrl_ff[`SGCF_CTRL_EN_BIT];
  wire [7:0] data_idx = {2'h0, byte_idx_ff - `SGCF_BYTE_IDX_DATA0};

  // Receiver: sample on SCL rise, drive acknowledge from SCL fall to the next fall
  always @(posedge i_clk) begin
    if (i_rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      byte_idx_ff <= 6'h00;
      cmd_ff <= 8'h00;
      bcount_ff <= 8'h00;
      data_cnt_ff <= 8'h00;
      cfg0_ff <= `SGCF_CFG0_RST;
      cfg1_ff <= `SGCF_CFG1_RST;
      cfg2_ff <= `SGCF_CFG2_RST;
      o_sda <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      o_sda <= 1'b0;
      if (stop_ev) begin
        state_ff <= ST_IDLE;
        o_sda_oe_n <= 1'b1;
      end else if (start_ev) begin
        state_ff <= ST_RECV;
        bit_cnt_ff <= 4'h0;
        byte_idx_ff <= `SGCF_BYTE_IDX_ADDR;
        o_sda_oe_n <= 1'b1;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            o_sda_oe_n <= 1'b1;
          end
          ST_RECV: begin
            if (scl_rise && bit_cnt_ff < 4'h8) begin
              shift_ff <= {shift_ff[6:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end else if (scl_fall && bit_cnt_ff == 4'h8) begin
              bit_cnt_ff <= 4'h0;
              if (byte_idx_ff == `SGCF_BYTE_IDX_ADDR) begin
                // Direction bit is ignored: only writes exist
                if (shift_ff[7:1] == `SGCF_SLAVE_ADDR && slave_en) begin
                  state_ff <= ST_ACK;
                  o_sda_oe_n <= 1'b0;
                  data_cnt_ff <= 8'h00;
                end else begin
                  state_ff <= ST_DROP;
                end
              end else begin
                state_ff <= ST_ACK;
                o_sda_oe_n <= 1'b0;
                if (byte_idx_ff == `SGCF_BYTE_IDX_CMD) begin
                  cmd_ff <= shift_ff;
                end else if (byte_idx_ff == `SGCF_BYTE_IDX_COUNT) begin
                  bcount_ff <= shift_ff;
                end else begin
                  if (data_cnt_ff != 8'hFF) begin
                    data_cnt_ff <= data_cnt_ff + 8'h01;
                  end
                  // Bytes past the stored set are acknowledged and dropped
                  case (data_idx)
                    8'h00: cfg0_ff <= shift_ff;
                    8'h01: cfg1_ff <= shift_ff;
                    8'h02: cfg2_ff <= shift_ff;
                    default: cfg0_ff <= cfg0_ff;
                  endcase
                end
              end
              if (byte_idx_ff != 6'h3F) begin
                byte_idx_ff <= byte_idx_ff + 6'h01;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              o_sda_oe_n <= 1'b1;
              state_ff <= ST_RECV;
            end
          end
          ST_DROP: begin
            o_sda_oe_n <= 1'b1;
          end
          default: begin
            state_ff <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  function [31:0] strb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer b;
    begin
      strb_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          strb_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  function known_addr;
    input [3:0] a;
    begin
      known_addr = (a == `SGCF_REG_CTRL) || (a == `SGCF_REG_GATE) ||
        (a == `SGCF_REG_STATUS) || (a == `SGCF_REG_APPLIED);
    end
  endfunction

  // Write channel: address and data taken in either order, answered after both
  always @(posedge i_clk) begin
    if (i_rst) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      aw_err_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SGCF_RESP_OKAY;
      ctrl_ff <= `SGCF_CTRL_RST;
    end else begin
      s_axi_awready <= ~aw_have_ff & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready <= ~w_have_ff & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[3:2], 2'h0};
        aw_err_ff <= (s_axi_awaddr[31:4] != 28'h0);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (aw_have_ff && w_have_ff && !s_axi_bvalid) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_err_ff || !known_addr(awaddr_ff)) begin
          s_axi_bresp <= `SGCF_RESP_SLVERR;
        end else begin
          s_axi_bresp <= `SGCF_RESP_OKAY;
        end
        if (awaddr_ff == `SGCF_REG_CTRL && !aw_err_ff) begin
          ctrl_ff <= strb_merge(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_0001;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address acceptance to data
  always @(posedge i_clk) begin
    if (i_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SGCF_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SGCF_RESP_OKAY;
        case ({s_axi_araddr[3:2], 2'h0})
          `SGCF_REG_CTRL: s_axi_rdata <= ctrl_ff;
          `SGCF_REG_GATE: s_axi_rdata <= {8'h00, cfg2_ff, cfg1_ff, cfg0_ff};
          `SGCF_REG_STATUS: s_axi_rdata <= {15'h0000, (state_ff != ST_IDLE),
            data_cnt_ff, bcount_ff};
          `SGCF_REG_APPLIED: s_axi_rdata <= {22'h00_0000, gate_applied};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SGCF_RESP_SLVERR;
          end
        endcase
        if (s_axi_araddr[31:4] != 28'h0) begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SGCF_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// ### verification/sgcf_monitor.sv
// Port checker for the serial gated clock fanout
`timescale 1ns/1ps
module sgcf_monitor #(parameter N = 10) (
  input wire i_clk,
  input wire i_rst,
  input wire i_src_clk,
  input wire i_oe,
  input wire i_scl,
  input wire o_sda,
  input wire o_sda_oe_n,
  input wire [N-1:0] o_fanout_copy_n,
  input wire [N-1:0] o_fanout_copy_n_oe_n
);
  // Saturating run lengths of the unsynchronised source and enable inputs
  logic [3:0] lo_ff, hi_ff, off_ff, on_ff;
  always @(posedge i_clk) begin
    lo_ff <= (i_rst || i_src_clk) ? 4'h0 : lo_ff + {3'h0, ~&lo_ff};
    hi_ff <= (i_rst || !i_src_clk) ? 4'h0 : hi_ff + {3'h0, ~&hi_ff};
    off_ff <= (i_rst || i_oe) ? 4'h0 : off_ff + {3'h0, ~&off_ff};
    on_ff <= (i_rst || !i_oe) ? 4'h0 : on_ff + {3'h0, ~&on_ff};
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_OE_OFF_Z: assert property (off_ff > 4'h7 |-> &o_fanout_copy_n_oe_n)
    else $error("copies driven while enable low");
  AST_OE_UNIFORM: assert property ((&o_fanout_copy_n_oe_n) || !(|o_fanout_copy_n_oe_n))
    else $error("copy enables disagree");
  AST_SRC_LO_ZERO: assert property (lo_ff > 4'h7 |-> o_fanout_copy_n == '0)
    else $error("copy high with source low");
  AST_RISE_SRC: assert property (|(o_fanout_copy_n & ~$past(o_fanout_copy_n)) |-> lo_ff < 4'h8)
    else $error("copy rose without source");
  // A gate change in a high phase would cut a pulse short
  AST_NO_RUNT: assert property
    (on_ff > 4'h7 && |(~o_fanout_copy_n & $past(o_fanout_copy_n)) |-> hi_ff < 4'h8)
    else $error("copy fell inside source high phase");
  AST_ACK_LOW: assert property (!o_sda_oe_n |-> !o_sda)
    else $error("data pin driven high");
  AST_SDA_SCL_LO: assert property ($changed(o_sda_oe_n) |-> !i_scl)
    else $error("data pin changed while serial clock high");
  AST_ACK_SPAN: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*8] ##[1:24] o_sda_oe_n)
    else $error("acknowledge length wrong");
  cover property ($fell(o_sda_oe_n));
  cover property (&o_fanout_copy_n_oe_n);
  cover property ($rose(o_fanout_copy_n[0]));
endmodule

bind sgcf_top sgcf_monitor #(.N(N)) u_mon (.i_clk, .i_rst, .i_src_clk, .i_oe, .i_scl,
  .o_sda, .o_sda_oe_n, .o_fanout_copy_n, .o_fanout_copy_n_oe_n);

// ### verification/sgcf_i2c_master.sv
// Behavioural two-wire bus controller writing to the fanout
`timescale 1ns/1ps
module sgcf_i2c_master (
  output logic o_scl,
  output logic o_sda,
  input wire i_sda
);
  localparam int Q = 40;
  // Clock idles high between frames; data released means pulled up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task wr(input logic [7:0] d, output logic ak);
    begin
      for (int i = 7; i >= 0; i--) begin
        #Q o_sda = d[i];
        #Q o_scl = 1'b1;
        #(2*Q) o_scl = 1'b0;
      end
      #Q o_sda = 1'b1;
      #Q o_scl = 1'b1;
      #Q ak = !i_sda;
      #Q o_scl = 1'b0;
    end
  endtask
  // Address then up to six bytes: command, count, data from byte zero
  task frame(input logic [7:0] a, input logic [47:0] b, input int n, output int nk);
    logic ak;
    begin
      nk = 0;
      #3 o_sda = 1'b0;
      #Q o_scl = 1'b0;
      wr(a, ak);
      nk += !ak;
      for (int i = 0; i < n; i++) begin
        wr(b[47-8*i -: 8], ak);
        nk += !ak;
      end
      #Q o_sda = 1'b0;
      #Q o_scl = 1'b1;
      #Q o_sda = 1'b1;
      #Q;
    end
  endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the serial gated clock fanout
`timescale 1ns/1ps
`include "sgcf_defs.vh"
module tb_top;
  logic i_clk = 1'b0, i_rst = 1'b1, i_src_clk = 1'b0, i_oe = 1'b0;
  logic [3:0] div_ff = 4'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire o_sda, o_sda_oe_n, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid, scl, m_sda, sda_line;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [9:0] cp, cp_oe_n;
  int n_errors = 0, compares = 0, nk;
  // Pull-up on the data wire; either party may pull it low
  assign sda_line = m_sda & (o_sda_oe_n | o_sda);
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    div_ff <= (div_ff == 4'h9) ? 4'h0 : div_ff + 4'h1;
    if (div_ff == 4'h9) i_src_clk <= ~i_src_clk;
  end
  sgcf_top i_dut (.i_clk, .i_rst, .i_src_clk, .i_oe, .i_scl(scl), .i_sda(sda_line), .o_sda,
    .o_sda_oe_n, .o_fanout_copy_n(cp), .o_fanout_copy_n_oe_n(cp_oe_n), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sgcf_i2c_master i_mst (.o_scl(scl), .o_sda(m_sda), .i_sda(sda_line));
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    @(posedge i_clk);
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge i_clk);
      if (s_axi_awready && !ad) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready && !wd) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge i_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge i_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge i_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge i_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Copies lag the source by the synchroniser, so look late in the phase
  task settle(input logic lvl);
    @(posedge i_clk iff i_src_clk !== lvl);
    @(posedge i_clk iff i_src_clk === lvl);
    repeat (8) @(posedge i_clk);
  endtask
  task fr(input logic [7:0] a, input logic [47:0] b, input int n, input int en);
    i_mst.frame(a, b, n, nk);
    chk(nk, en);
  endtask
  task t_oe;
    chk({22'h0, cp_oe_n}, 32'h3FF);
    i_oe <= 1'b1;
    settle(1'b1);
    chk({22'h0, cp}, 32'h3FF);
    chk({22'h0, cp_oe_n}, 32'h0);
    settle(1'b0);
    chk({22'h0, cp}, 32'h0);
  endtask
  task t_frame;
    fr(8'hD2, 48'h0004_05A0_80FF, 6, 0);
    axi_rd({28'h0, `SGCF_REG_GATE}, 32'h0080_A005, `SGCF_RESP_OKAY);
    settle(1'b1);
    chk({22'h0, cp}, 32'h2A5);
    fr(8'hD3, 48'h0003_0FF0_C000, 5, 0);
    settle(1'b1);
    chk({22'h0, cp}, 32'h3FF);
  endtask
  task t_addr;
    for (int k = 1; k < 8; k++) fr(8'hD2 ^ (8'h01 << k), 48'h0003_0000_0000, 5, 6);
    axi_rd({28'h0, `SGCF_REG_GATE}, 32'h00C0_F00F, `SGCF_RESP_OKAY);
  endtask
  task t_axi;
    axi_rd({28'h0, `SGCF_REG_CTRL}, `SGCF_CTRL_RST, `SGCF_RESP_OKAY);
    axi_wr({28'h0, `SGCF_REG_CTRL}, 32'h0, `SGCF_RESP_OKAY);
    fr(8'hD2, 48'h0003_0000_0000, 5, 6);
    axi_wr({28'h0, `SGCF_REG_CTRL}, 32'h1, `SGCF_RESP_OKAY);
    axi_wr({28'h0, `SGCF_REG_GATE}, 32'h0, `SGCF_RESP_OKAY);
    axi_rd({28'h0, `SGCF_REG_GATE}, 32'h00C0_F00F, `SGCF_RESP_OKAY);
    axi_rd(32'h10, 32'h0, `SGCF_RESP_SLVERR);
    axi_wr(32'h10, 32'h0, `SGCF_RESP_SLVERR);
    axi_rd({28'h0, `SGCF_REG_APPLIED}, 32'h3FF, `SGCF_RESP_OKAY);
  endtask
  task t_short;
    fr(8'hD2, 48'h0001_0000_0000, 3, 0);
    settle(1'b1);
    chk({22'h0, cp}, 32'h3F0);
    i_oe <= 1'b0;
    settle(1'b1);
    chk({22'h0, cp_oe_n}, 32'h3FF);
  endtask
  task final_report;
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    t_oe;
    t_frame;
    t_addr;
    t_axi;
    t_short;
    final_report;
  end
  initial begin
    #300000;
    n_errors++;
    final_report;
  end
endmodule
